// ==== hdl/adc_conversion_control.sv ====
// converter control: registers, conversion timing and result update
// Operation
// - result register read-only, 16-bit signed, left-aligned at bit 15
// - period code 0..7 gives 32..4096 converter clocks, 7..14 bits
// - positive selector codes route pins, ground, references, half supply
// - negative selector in bits 6:3 uses same code table
// - clock select 0 gives 6 MHz, 1 gives 1 MHz
// - run bit one starts continuous conversions, zero stops them
// - first conversion after start takes double clocks plus 21 us
// - configuration change while running doubles next conversion length
// - signed offset added to raw result before gain
// - configuration resets to 0x00001800
// - offset and result registers reset to zero
// - result multiplied by unsigned gain, point between 15 and 14
//
// Our own choice: the strobed register port.
module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int START_DELAY = START_CYCLES
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    // register port
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    output logic      [31:0] rdata_o,
    // converter analogue side
    input  wire logic [15:0] sample_i,
    output logic      [3:0]  positive_input_sel_o,
    output logic      [3:0]  negative_input_sel_o,
    output logic             slow_clock_sel_o,
    output logic             converting_o,
    output logic             conv_clk_en_o,
    output logic             result_valid_o
);
    typedef enum logic [1:0] {IDLE, WARMUP, CONVERT} conv_state_t;

    conv_state_t          state_reg;
    conv_state_t          state_next;
    logic [CONFIG_W-1:0]  config_reg;
    logic [15:0]          offset_reg;
    logic [15:0]          gain_reg;
    logic [31:0]          rdata_reg;
    logic [DIV_W-1:0]     div_reg;
    logic [CNT_W:0]       count_reg;
    logic [31:0]          warm_reg;
    logic                 double_reg;
    logic                 tick_reg;
    logic                 done_reg;
    logic [15:0]          result;

    // sample pins come from the analogue domain
    logic [15:0]          samp_s1_reg;
    logic [15:0]          samp_s2_reg;
    logic [15:0]          samp_s3_reg;
    logic [15:0]          samp_reg;

    wire logic            wr_config = write_i && (addr_i == CONFIG_ADDR);
    wire logic            wr_offset = write_i && (addr_i == OFFSET_ADDR);
    wire logic            wr_gain   = write_i && (addr_i == GAIN_ADDR);
    wire logic [15:0]     new_cfg   = wdata_i[15:0];
    wire logic            run       = config_reg[RUN_BIT];
    wire logic            cfg_change = wr_config && run && new_cfg[RUN_BIT]
                                       && (new_cfg != config_reg);
    wire logic [2:0]      period    = config_reg[PERIOD_MSB:PERIOD_LSB];
    wire logic [DIV_W-1:0] div_last = config_reg[SLOW_CLK_BIT] ?
                                       DIV_W'(SLOW_DIV - 1) : DIV_W'(FAST_DIV - 1);
    wire logic [CNT_W:0]  conv_len;
    wire logic            warm_done = (warm_reg == 32'(START_DELAY - 1));
    wire logic            conv_end  = tick_reg && (count_reg == conv_len - 1'b1);
    wire logic [15:0]     samp_masked;
    wire logic            load_result = state_reg == CONVERT && conv_end && !cfg_change && run;

    // length and significant bits from period code
    function automatic logic [CNT_W:0] period_clocks(input logic [2:0] code);
        period_clocks = (CNT_W+1)'(BASE_CLOCKS) << code;
    endfunction

    function automatic logic [15:0] keep_mask(input logic [2:0] code);
        keep_mask = 16'($signed(16'hFE00) >>> code);
    endfunction

    // doubled length on start, doubled after a change
    assign conv_len = double_reg ? (period_clocks(period) << 1) : period_clocks(period);
    assign samp_masked = samp_reg & keep_mask(period);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IDLE:    if (run) state_next = WARMUP;
            WARMUP:  if (!run) state_next = IDLE;
                     else if (warm_done) state_next = CONVERT;
            CONVERT: if (!run) state_next = IDLE;
            default: state_next = IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            config_reg <= CONFIG_W'(CONFIG_RESET);
        end else if (ce_i && wr_config) begin
            config_reg <= new_cfg;
        end
    end

    // offset reset to zero, gain reset to one
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            offset_reg <= OFFSET_RESET;
            gain_reg   <= GAIN_RESET;
        end else if (ce_i) begin
            if (wr_offset) offset_reg <= wdata_i[15:0];
            if (wr_gain) gain_reg <= wdata_i[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            samp_s1_reg <= 16'h0000;
            samp_s2_reg <= 16'h0000;
            samp_s3_reg <= 16'h0000;
            samp_reg    <= 16'h0000;
        end else if (ce_i) begin
            samp_s1_reg <= sample_i;
            samp_s2_reg <= samp_s1_reg;
            samp_s3_reg <= samp_s2_reg;
            if (samp_s2_reg == samp_s3_reg) samp_reg <= samp_s3_reg;
        end
    end

    // run bit starts and stops the sequence
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= IDLE;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_reg  <= {DIV_W{1'b0}};
            tick_reg <= 1'b0;
        end else if (ce_i && !run) begin
            div_reg  <= {DIV_W{1'b0}};
            tick_reg <= 1'b0;
        end else if (ce_i) begin
            tick_reg <= (div_reg >= div_last);
            div_reg  <= (div_reg >= div_last) ? {DIV_W{1'b0}} : div_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            warm_reg <= 32'h00000000;
        end else if (ce_i && state_reg != WARMUP) begin
            warm_reg <= 32'h00000000;
        end else if (ce_i) begin
            warm_reg <= warm_reg + 32'h00000001;
        end
    end

    // first conversion doubled, change doubles next
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            double_reg <= 1'b0;
            count_reg  <= '0;
            done_reg   <= 1'b0;
        end else if (ce_i) begin
            done_reg <= 1'b0;
            if (state_reg == IDLE) begin
                double_reg <= 1'b1;
                count_reg  <= '0;
            end else if (cfg_change || (wr_config && !new_cfg[RUN_BIT])) begin
                double_reg <= 1'b1;
                count_reg  <= '0;
            end else if (state_reg == CONVERT && conv_end) begin
                double_reg <= 1'b0;
                count_reg  <= '0;
                done_reg   <= 1'b1;
            end else if (state_reg == CONVERT && tick_reg) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // corrected result loaded at conversion end
    adc_result_path u_result (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .ce_i     (ce_i),
        .load_i   (load_result),
        .raw_i    (samp_masked),
        .offset_i (offset_reg),
        .gain_i   (gain_reg),
        .result_o (result)
    );

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_reg <= 32'h00000000;
        end else if (ce_i) begin
            rdata_reg <= 32'h00000000;
            if (read_i) begin
                case (addr_i)
                    RESULT_ADDR: rdata_reg <= {16'h0000, result};
                    CONFIG_ADDR: rdata_reg <= {16'h0000, config_reg};
                    OFFSET_ADDR: rdata_reg <= {16'h0000, offset_reg};
                    GAIN_ADDR:   rdata_reg <= {16'h0000, gain_reg};
                    default:     rdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    // selectors and clock choice drive the analogue side
    logic [3:0] pos_reg;
    logic [3:0] neg_reg;
    logic       slow_reg;
    logic       conv_reg;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pos_reg  <= 4'h0;
            neg_reg  <= 4'h0;
            slow_reg <= 1'b0;
            conv_reg <= 1'b0;
        end else if (ce_i) begin
            pos_reg  <= config_reg[POS_SEL_MSB:POS_SEL_LSB];
            neg_reg  <= config_reg[NEG_SEL_MSB:NEG_SEL_LSB];
            slow_reg <= config_reg[SLOW_CLK_BIT];
            conv_reg <= (state_reg == CONVERT);
        end
    end

    assign rdata_o              = rdata_reg;
    assign positive_input_sel_o = pos_reg;
    assign negative_input_sel_o = neg_reg;
    assign slow_clock_sel_o     = slow_reg;
    assign converting_o         = conv_reg;
    assign conv_clk_en_o        = tick_reg;
    assign result_valid_o       = done_reg;

    // config reads reset value after reset
    config_reset_a: assert property (@(posedge clk_i)
        $past(reset_i) |-> config_reg == CONFIG_W'(CONFIG_RESET))
        else $error("config not at reset value");

    run_stop_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && !run && state_reg != IDLE) |=> state_reg == IDLE)
        else $error("conversion did not stop");

    warm_first_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_reg == IDLE && state_next == WARMUP) |=> double_reg)
        else $error("first conversion not doubled");

    change_double_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && cfg_change) |=> double_reg && count_reg == '0)
        else $error("change did not double conversion");

    result_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && result_valid_o) |=> !result_valid_o)
        else $error("result valid longer than one cycle");

    read_upper_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rdata_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    count_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
        count_reg < conv_len)
        else $error("conversion count beyond length");

    offset_reset_a: assert property (@(posedge clk_i)
        $past(reset_i) |-> offset_reg == OFFSET_RESET && result == RESULT_RESET)
        else $error("offset or result not zero after reset");

    pos_route_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i |=> positive_input_sel_o == $past(config_reg[POS_SEL_MSB:POS_SEL_LSB]))
        else $error("positive selector not routed");

    neg_route_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i |=> negative_input_sel_o == $past(config_reg[NEG_SEL_MSB:NEG_SEL_LSB]))
        else $error("negative selector not routed");

    idle_quiet_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && state_reg == IDLE) |=> !converting_o)
        else $error("converting while idle");
endmodule

// ==== hdl/adc_ctrl_pkg.sv ====
// constants for the converter control block
package adc_ctrl_pkg;
    localparam int         ADDR_W          = 32;
    localparam int         DATA_W          = 32;
    localparam logic [31:0] RESULT_ADDR    = 32'h4000D000;
    localparam logic [31:0] CONFIG_ADDR    = 32'h4000D004;
    localparam logic [31:0] OFFSET_ADDR    = 32'h4000D008;
    localparam logic [31:0] GAIN_ADDR      = 32'h4000D00C;
    localparam logic [31:0] CONFIG_RESET   = 32'h00001800;
    localparam logic [15:0] OFFSET_RESET   = 16'h0000;
    localparam logic [15:0] RESULT_RESET   = 16'h0000;
    localparam logic [15:0] GAIN_RESET     = 16'h8000;
    localparam int         PERIOD_MSB      = 15;
    localparam int         PERIOD_LSB      = 13;
    localparam int         RSVD_PAIR_MSB   = 12;
    localparam int         RSVD_PAIR_LSB   = 11;
    localparam int         POS_SEL_MSB     = 10;
    localparam int         POS_SEL_LSB     = 7;
    localparam int         NEG_SEL_MSB     = 6;
    localparam int         NEG_SEL_LSB     = 3;
    localparam int         SLOW_CLK_BIT    = 2;
    localparam int         RSVD_SINGLE_BIT = 1;
    localparam int         RUN_BIT         = 0;
    localparam int         CONFIG_W        = 16;
    localparam int         BASE_CLOCKS     = 32;
    localparam int         GAIN_FRAC       = 15;
    localparam int         CLK_MHZ         = 250;
    localparam int         FAST_MHZ        = 6;
    localparam int         SLOW_MHZ        = 1;
    localparam int         START_US        = 21;
    // system clocks per converter clock, rounded down
    localparam int         FAST_DIV        = CLK_MHZ / FAST_MHZ;
    localparam int         SLOW_DIV        = CLK_MHZ / SLOW_MHZ;
    // start-up delay in system clocks, a least time rounded up
    localparam int         START_CYCLES    = START_US * CLK_MHZ;
    localparam int         DIV_W           = 8;
    localparam int         CNT_W           = 14;
    localparam int         START_W         = 13;
endpackage

// ==== hdl/adc_result_path.sv ====
// offset and gain correction of one raw conversion result
module adc_result_path
    import adc_ctrl_pkg::*;
(
    // clock and control
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic        load_i,
    // operands
    input  wire logic [15:0] raw_i,
    input  wire logic [15:0] offset_i,
    input  wire logic [15:0] gain_i,
    // corrected result
    output logic      [15:0] result_o
);
    logic signed [16:0] sum;
    logic signed [33:0] product;
    logic signed [33:0] scaled;
    logic        [15:0] result_reg;
    logic        [15:0] result_next;

    assign sum = 17'(signed'(raw_i)) + 17'(signed'(offset_i));
    // unsigned gain, binary point at 15
    assign product = 34'(sum) * signed'({18'h00000, gain_i});
    assign scaled = product >>> GAIN_FRAC;
    assign result_next = (scaled > 34'sh07FFF) ? 16'h7FFF :
                         (scaled < -34'sh08000) ? 16'h8000 : scaled[15:0];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            result_reg <= RESULT_RESET;
        end else if (ce_i && load_i) begin
            result_reg <= result_next;
        end
    end

    assign result_o = result_reg;
endmodule

// ==== testbench/adc_conversion_control_tb_top.sv ====
// self-checking bench for the converter control block
module adc_conversion_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_ctrl_pkg::*;
    localparam int START_SIM = 20;
    logic        clk_i;
    logic        reset_i;
    logic        ce_i;
    logic [31:0] addr_i;
    logic [31:0] wdata_i;
    logic        write_i;
    logic        read_i;
    logic [31:0] rdata_o;
    logic [15:0] sample_i;
    logic [3:0]  positive_input_sel_o;
    logic [3:0]  negative_input_sel_o;
    logic        slow_clock_sel_o;
    logic        converting_o;
    logic        conv_clk_en_o;
    logic        result_valid_o;
    logic [3:0]  codes [10];
    int          failures;
    int          n_tests;
    int          n;
    int          t;
    adc_conversion_control #(.START_DELAY(START_SIM)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .sample_i(sample_i),
        .positive_input_sel_o(positive_input_sel_o),
        .negative_input_sel_o(negative_input_sel_o), .slow_clock_sel_o(slow_clock_sel_o),
        .converting_o(converting_o), .conv_clk_en_o(conv_clk_en_o),
        .result_valid_o(result_valid_o));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout;
        failures++;
        $display("Error at %0t: wait ran out", $time);
        report_and_stop();
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        write_i <= 1'b1;
        @(posedge clk_i);
        write_i <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    // converter ticks from here up to the next result pulse
    task automatic count_conv(output int c);
        int i;
        c = 0;
        for (i = 0; i < 25000; i++) begin
            @(posedge clk_i);
            #1;
            if (conv_clk_en_o === 1'b1) c++;
            if (result_valid_o === 1'b1) break;
        end
        if (i == 25000) timeout();
    endtask
    // system clocks between two converter ticks
    task automatic tick_gap(output int g);
        int i;
        g = 0;
        for (i = 0; i < 300; i++) begin
            @(posedge clk_i);
            #1;
            if (conv_clk_en_o === 1'b1) break;
        end
        if (i == 300) timeout();
        for (i = 0; i < 300; i++) begin
            @(posedge clk_i);
            #1;
            g++;
            if (conv_clk_en_o === 1'b1) break;
        end
        if (i == 300) timeout();
    endtask
    initial begin
        codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB};
        failures = 0;
        n_tests = 0;
        reset_i = 1'b1;
        ce_i = 1'b1;
        addr_i = 32'h0;
        wdata_i = 32'h0;
        write_i = 1'b0;
        read_i = 1'b0;
        sample_i = 16'h1234;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        // reset values and read-only result
        rd_chk(CONFIG_ADDR, 32'h00001800);
        rd_chk(OFFSET_ADDR, 32'h00000000);
        rd_chk(RESULT_ADDR, 32'h00000000);
        rd_chk(GAIN_ADDR, 32'h00008000);
        rd_chk(32'h4000D020, 32'h00000000);
        wr(RESULT_ADDR, 32'h0000FFFF);
        rd_chk(RESULT_ADDR, 32'h00000000);
        // every valid selector code on both channels, clock select both ways
        for (int k = 0; k < 10; k++) begin
            wr(CONFIG_ADDR, (32'(codes[k]) << 7) | (32'(codes[9 - k]) << 3) | (32'(k % 2) << 2));
            repeat (2) @(posedge clk_i);
            #1;
            chk(32'(positive_input_sel_o), 32'(codes[k]));
            chk(32'(negative_input_sel_o), 32'(codes[9 - k]));
            chk(32'(slow_clock_sel_o), 32'(k % 2));
        end
        rd_chk(CONFIG_ADDR, 32'h00000584);
        // start: warm-up, doubled first conversion, offset then gain
        wr(OFFSET_ADDR, 32'h00000010);
        wr(CONFIG_ADDR, 32'h00000001);
        t = 1;
        while (converting_o !== 1'b1 && t < 1000) begin
            @(posedge clk_i);
            #1;
            t++;
        end
        chk(32'(t >= START_SIM), 32'h1);
        count_conv(n);
        chk(32'(n), 32'd64);
        rd_chk(RESULT_ADDR, 32'h00001210);
        count_conv(n);
        chk(32'(n), 32'd32);
        tick_gap(n);
        chk(32'(n), 32'(FAST_DIV));
        wr(GAIN_ADDR, 32'h00004000);
        count_conv(n);
        count_conv(n);
        rd_chk(RESULT_ADDR, 32'h00000908);
        sample_i <= 16'h0000;
        wr(OFFSET_ADDR, 32'h0000FF00);
        count_conv(n);
        count_conv(n);
        rd_chk(RESULT_ADDR, 32'h0000FF80);
        // configuration change while running doubles the next conversion
        count_conv(n);
        wr(CONFIG_ADDR, 32'h00000081);
        count_conv(n);
        chk(32'(n), 32'd64);
        // period codes: length and left-aligned significant bits
        wr(GAIN_ADDR, 32'h00008000);
        wr(OFFSET_ADDR, 32'h00000000);
        sample_i <= 16'hFFFF;
        for (int p = 0; p < 4; p++) begin
            wr(CONFIG_ADDR, (32'(p) << 13) | 32'h1);
            count_conv(n);
            count_conv(n);
            chk(32'(n), 32'(32 << p));
            rd_chk(RESULT_ADDR, 32'hFFFF & ~((32'h1 << (9 - p)) - 32'h1));
        end
        // slow converter clock, then stop
        wr(CONFIG_ADDR, 32'h00000005);
        tick_gap(n);
        chk(32'(n), 32'(SLOW_DIV));
        wr(CONFIG_ADDR, 32'h00000000);
        repeat (3) @(posedge clk_i);
        #1;
        chk(32'(converting_o), 32'h0);
        n = 0;
        repeat (600) begin
            @(posedge clk_i);
            #1;
            if (result_valid_o !== 1'b0) n++;
        end
        chk(32'(n), 32'h0);
        // writes ignored while the clock enable is low, read data stands one cycle
        ce_i <= 1'b0;
        wr(OFFSET_ADDR, 32'h00001234);
        ce_i <= 1'b1;
        rd_chk(OFFSET_ADDR, 32'h00000000);
        rd_chk(GAIN_ADDR, 32'h00008000);
        @(posedge clk_i);
        #1;
        chk(rdata_o, 32'h00000000);
        report_and_stop();
    end
endmodule
